// ===== core/complex_multiplier_regs.vh
// Register map, field positions and reset values of the multiplier formatting block
`ifndef COMPLEX_MULTIPLIER_REGS_VH
`define COMPLEX_MULTIPLIER_REGS_VH

// Byte offsets on the register bus
`define OFS_CONTROL 8'h00
`define OFS_CARRIER 8'h04
`define OFS_STATUS 8'h08
`define OFS_ACC_REAL 8'h0c
`define OFS_ACC_IMAG 8'h10

// Control register fields
`define CTL_SHIFT_LO 0
`define CTL_SOURCE_LO 2
`define CTL_SUM_BIT 4
`define CTL_BINARY_BIT 5
`define CTL_HOLD_BIT 6
`define CTL_WIDTH 7
`define CTL_RESET 7'h20

// Carrier register fields and reset value
`define CAR_COS_LO 0
`define CAR_SIN_LO 16
`define CAR_RESET 32'h00007fff

// Output source codes
`define SRC_COMPLEX_MULTIPLIER 2'h0
`define SRC_COMPLEX_MULTIPLIER_LOW 2'h1
`define SRC_ACC 2'h2

// Sample path
`define IN_WIDTH 19
`define OUT_WIDTH 20
`define FIFO_DEPTH 32

// Bus constants
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// ===== core/stream_fifo.v
// Synchronous valid/ready FIFO with registered full and empty flags
module stream_fifo #(
  parameter WIDTH = 38,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Filling side
  input wire inValid,
  output reg inReady,
  input wire [WIDTH-1:0] inData,
  // Draining side
  output reg outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire push;
  wire pop;
  reg [AW:0] next_count;

  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = store[rdPtr];

  // Occupancy after this cycle's push and pop
  always @* begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage array carries no reset, only the pointers, count and flags do
  always @(posedge clk_sys) begin
    if (push) begin
      store[wrPtr] <= inData;
    end
  end

  // Pointers and flags, flags registered from the next occupancy
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= next_count;
      inReady <= (next_count != DEPTH[AW:0]);
      outValid <= (next_count != {(AW+1){1'b0}});
    end
  end

endmodule // stream_fifo

// ===== core/complex_multiplier_io_format_accumulate.v
// Input shifter, complex multiply-accumulate, output formatting and growth detector
`include "complex_multiplier_regs.vh"

module complex_multiplier_io_format_accumulate (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Register bus, AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Sample stream in
  input wire sampleValid,
  output wire sampleReady,
  input wire [18:0] realInputBus,
  input wire [18:0] imagInputBus,
  // Result stream out
  output reg outValid,
  input wire outReady,
  output reg [19:0] realOutputBus,
  output reg [19:0] imagOutputBus,
  // Growth detector
  output reg [1:0] growthIndicator
);

  // Software-visible registers
  reg [`CTL_WIDTH-1:0] control;
  reg [31:0] carrier;
  // Control bits as sampled by the datapath
  reg [1:0] inputShiftSelect;
  reg [1:0] outputSourceSelect;
  reg sumOrUnloadControl;
  reg offsetBinarySelect;
  reg maxGrowthHold;
  // Bus data phase state
  reg wrPending;
  reg [7:0] wrAddr;
  wire addrPhase;
  reg [31:0] next_hrdata;
  // Stream and FIFO
  wire fifoReady;
  wire fifoValid;
  wire [37:0] fifoData;
  wire stall;
  wire take;
  reg pipeValid;
  // Multiplier operands and products
  wire [18:0] fifoReal;
  wire [18:0] fifoImag;
  wire signed [15:0] opReal;
  wire signed [15:0] opImag;
  wire signed [15:0] carCos;
  wire signed [15:0] carSin;
  wire signed [31:0] prodRc;
  wire signed [31:0] prodIs;
  wire signed [31:0] prodRs;
  wire signed [31:0] prodIc;
  wire [34:0] prodReal;
  wire [34:0] prodImag;
  // Accumulators and holding registers
  reg [19:0] accReal;
  reg [19:0] accImag;
  reg [19:0] accHoldReal;
  reg [19:0] accHoldImag;
  reg [34:0] cmacHoldReal;
  reg [34:0] cmacHoldImag;
  wire [19:0] feedReal;
  wire [19:0] feedImag;
  // Output formatting
  reg [19:0] next_realOut;
  reg [19:0] next_imagOut;
  // Growth detector
  wire [4:0] windowBits [0:3];
  wire [1:0] growth [0:3];
  wire [1:0] growthMax01;
  wire [1:0] growthMax23;
  wire [1:0] growthNow;
  reg [1:0] peakGrowth;
  wire [1:0] next_peak;

  // Bus: a transfer is taken while selected, NONSEQ or SEQ, and the bus is ready
  assign addrPhase = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;

  // Read data is chosen in the address phase so the slave never waits
  always @* begin
    next_hrdata = 32'h00000000;
    case (haddr[7:0])
      `OFS_CONTROL: begin
        next_hrdata = {25'h0000000, control};
      end
      `OFS_CARRIER: begin
        next_hrdata = carrier;
      end
      `OFS_STATUS: begin
        next_hrdata = {24'h000000, 1'b0, sumOrUnloadControl, pipeValid, outValid,
                       fifoReady, fifoValid, growthIndicator};
      end
      `OFS_ACC_REAL: begin
        next_hrdata = {12'h000, accHoldReal};
      end
      `OFS_ACC_IMAG: begin
        next_hrdata = {12'h000, accHoldImag};
      end
      default: begin
        next_hrdata = 32'h00000000;
      end
    endcase
    if (haddr[31:8] != 24'h000000) begin
      next_hrdata = 32'h00000000;
    end
  end

  // Bus slave: zero wait states, always OKAY, writes land in the data phase
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b0;
      hresp <= `HRESP_OKAY;
      hrdata <= 32'h00000000;
      wrPending <= 1'b0;
      wrAddr <= 8'h00;
      control <= `CTL_RESET;
      carrier <= `CAR_RESET;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      if (addrPhase & ~hwrite) begin
        hrdata <= next_hrdata;
      end
      wrPending <= addrPhase & hwrite & (haddr[31:8] == 24'h000000);
      wrAddr <= haddr[7:0];
      if (wrPending) begin
        case (wrAddr)
          `OFS_CONTROL: begin
            control <= hwdata[`CTL_WIDTH-1:0];
          end
          `OFS_CARRIER: begin
            carrier <= hwdata;
          end
          default: begin
            control <= control;
          end
        endcase
      end
    end
  end

  // Control bits pass one register before the datapath sees them
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inputShiftSelect <= 2'h0;
      outputSourceSelect <= 2'h0;
      sumOrUnloadControl <= 1'b0;
      offsetBinarySelect <= 1'b1;
      maxGrowthHold <= 1'b0;
    end else begin
      inputShiftSelect <= control[`CTL_SHIFT_LO +: 2];
      outputSourceSelect <= control[`CTL_SOURCE_LO +: 2];
      sumOrUnloadControl <= control[`CTL_SUM_BIT];
      offsetBinarySelect <= control[`CTL_BINARY_BIT];
      maxGrowthHold <= control[`CTL_HOLD_BIT];
    end
  end

  // Samples queue here so a slow converter pushes back on the source
  stream_fifo #(
    .WIDTH(38),
    .DEPTH(`FIFO_DEPTH),
    .AW(5)
  ) sampleQueue (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .inValid(sampleValid),
    .inReady(fifoReady),
    .inData({realInputBus, imagInputBus}),
    .outValid(fifoValid),
    .outReady(take),
    .outData(fifoData)
  );

  assign sampleReady = fifoReady;

  // The whole pipe freezes while a result waits at the output
  assign stall = outValid & ~outReady;
  assign take = fifoValid & ~stall;

  // Input shifter picks a 16-bit window of each bus
  assign fifoReal = fifoData[37:19];
  assign fifoImag = fifoData[18:0];
  assign opReal = fifoReal[inputShiftSelect +: 16];
  assign opImag = fifoImag[inputShiftSelect +: 16];
  assign carCos = carrier[`CAR_COS_LO +: 16];
  assign carSin = carrier[`CAR_SIN_LO +: 16];

  // Complex product, input times carrier, widened to 35 bits
  assign prodRc = opReal * carCos;
  assign prodIs = opImag * carSin;
  assign prodRs = opReal * carSin;
  assign prodIc = opImag * carCos;
  assign prodReal = {{3{prodRc[31]}}, prodRc} - {{3{prodIs[31]}}, prodIs};
  assign prodImag = {{3{prodRs[31]}}, prodRs} + {{3{prodIc[31]}}, prodIc};

  // Feedback is forced to zero in unload mode so the accumulator loads
  assign feedReal = sumOrUnloadControl ? accReal : 20'h00000;
  assign feedImag = sumOrUnloadControl ? accImag : 20'h00000;

  // Accumulators and product holding registers advance once per taken sample; total holding only in unload mode
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      accReal <= 20'h00000;
      accImag <= 20'h00000;
      accHoldReal <= 20'h00000;
      accHoldImag <= 20'h00000;
      cmacHoldReal <= 35'h000000000;
      cmacHoldImag <= 35'h000000000;
      pipeValid <= 1'b0;
    end else if (~stall) begin
      pipeValid <= take;
      if (take) begin
        cmacHoldReal <= prodReal;
        cmacHoldImag <= prodImag;
        accReal <= feedReal + prodReal[34:15];
        accImag <= feedImag + prodImag[34:15];
        // Totals move to holding on every taken sample in unload mode; summing leaves them frozen
        if (~sumOrUnloadControl) begin
          accHoldReal <= accReal;
          accHoldImag <= accImag;
        end
      end
    end
  end

  // Output source mux; the reserved code drives zero
  always @* begin
    case (outputSourceSelect)
      `SRC_COMPLEX_MULTIPLIER: begin
        next_realOut = {cmacHoldReal[34:31], cmacHoldReal[30:15]};
        next_imagOut = {cmacHoldImag[34:31], cmacHoldImag[30:15]};
      end
      `SRC_COMPLEX_MULTIPLIER_LOW: begin
        next_realOut = {cmacHoldReal[34:31], 1'b0, cmacHoldReal[14:0]};
        next_imagOut = {cmacHoldImag[34:31], 1'b0, cmacHoldImag[14:0]};
      end
      `SRC_ACC: begin
        next_realOut = accHoldReal;
        next_imagOut = accHoldImag;
      end
      default: begin
        next_realOut = 20'h00000;
        next_imagOut = 20'h00000;
      end
    endcase
    // Offset binary for converters wants the sign bit flipped
    if (~offsetBinarySelect) begin
      next_realOut[19] = ~next_realOut[19];
      next_imagOut[19] = ~next_imagOut[19];
    end
  end

  // Output registers load one cycle after the holding registers
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outValid <= 1'b0;
      realOutputBus <= 20'h00000;
      imagOutputBus <= 20'h00000;
    end else if (~stall) begin
      outValid <= pipeValid;
      if (pipeValid) begin
        realOutputBus <= next_realOut;
        imagOutputBus <= next_imagOut;
      end
    end
  end

  // Detector windows: four examined bits plus the bit just below
  assign windowBits[0] = accHoldReal[18:14];
  assign windowBits[1] = accHoldImag[18:14];
  assign windowBits[2] = cmacHoldReal[33:29];
  assign windowBits[3] = cmacHoldImag[33:29];

  // Growth per window counts top bits that no longer match the sign extension
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : growthCell
      assign growth[g] = (windowBits[g][4] != windowBits[g][3]) ? 2'h3 :
                         (windowBits[g][3] != windowBits[g][2]) ? 2'h2 :
                         (windowBits[g][2] != windowBits[g][1]) ? 2'h1 : 2'h0;
    end
  endgenerate

  // Largest growth of the four registers
  assign growthMax01 = (growth[0] > growth[1]) ? growth[0] : growth[1];
  assign growthMax23 = (growth[2] > growth[3]) ? growth[2] : growth[3];
  assign growthNow = (growthMax01 > growthMax23) ? growthMax01 : growthMax23;

  // Peak only ever rises while hold is low; hold high restarts it from now
  assign next_peak = (growthNow > peakGrowth) ? growthNow : peakGrowth;

  // Growth code register; a limitation is that the peak clears only via hold high or reset
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      peakGrowth <= 2'h0;
      growthIndicator <= 2'h0;
    end else if (maxGrowthHold) begin
      peakGrowth <= growthNow;
      growthIndicator <= growthNow;
    end else begin
      peakGrowth <= next_peak;
      growthIndicator <= next_peak;
    end
  end

endmodule // complex_multiplier_io_format_accumulate

// ===== test/complex_multiplier_io_monitor.sv
// Port-level checker for the multiplier formatting block
module complex_multiplier_io_monitor (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // Streams
  input wire sampleValid,
  input wire sampleReady,
  input wire outValid,
  input wire outReady,
  input wire [19:0] realOutputBus,
  input wire [19:0] imagOutputBus,
  input wire [1:0] growthIndicator
);
  timeunit 1ns;
  timeprecision 1ps;
  reg wrCtl;
  reg loadOk;
  reg prevOk;
  reg [6:0] ctl;
  reg [3:0] age;
  reg [6:0] pend;
  reg [19:0] lastR;
  reg [19:0] lastI;
  wire fresh = outValid && loadOk;
  // Three cycles cover the control register and its datapath copy; longer would miss short batches
  wire settled = age == 4'h3;
  // Shadow of control writes; age lets the pipeline settle before data checks
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrCtl <= 1'b0;
      ctl <= 7'h20;
      age <= 4'h0;
      pend <= 7'h0;
      loadOk <= 1'b1;
      prevOk <= 1'b0;
      lastR <= 20'h0;
      lastI <= 20'h0;
    end else begin
      wrCtl <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
      if (wrCtl) ctl <= hwdata[6:0];
      age <= wrCtl ? 4'h0 : (settled ? age : age + 4'h1);
      pend <= pend + {6'h0, sampleValid && sampleReady} - {6'h0, outValid && outReady};
      loadOk <= !outValid || outReady;
      prevOk <= !wrCtl && (prevOk || (fresh && settled));
      if (fresh) lastR <= realOutputBus;
      if (fresh) lastI <= imagOutputBus;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  bus_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
  bus_ready_a: assert property ($past(arst_n) |-> hreadyout) else $error("bus wait state seen");
  stall_hold_a: assert property (outValid && !outReady |=> outValid && $stable(realOutputBus)
    && $stable(imagOutputBus)) else $error("result changed while stalled");
  no_phantom_a: assert property (outValid |-> pend != 7'h0) else $error("result without sample");
  pipe_latency_a: assert property (sampleValid && sampleReady && pend == 7'h0 |=> !outValid ##1 !outValid
    ##[1:6] outValid) else $error("result latency wrong");
  msb_format_a: assert property (fresh && settled && ctl[3:2] == 2'h3 |->
    realOutputBus == {~ctl[5], 19'h0} && imagOutputBus == {~ctl[5], 19'h0}) else $error("msb format wrong");
  sum_freeze_a: assert property (fresh && prevOk && settled && ctl[4:2] == 3'b110 |->
    realOutputBus == lastR && imagOutputBus == lastI) else $error("holding changed while summing");
  growth_stall_a: assert property (settled && outValid && !outReady ##1 outValid && !outReady
    ##1 outValid && !outReady |=> $stable(growthIndicator)) else $error("growth moved while stalled");
endmodule // complex_multiplier_io_monitor

bind complex_multiplier_io_format_accumulate complex_multiplier_io_monitor complex_multiplier_io_monitor_inst (.clk_sys(clk_sys), .arst_n(arst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .sampleValid(sampleValid), .sampleReady(sampleReady),
  .outValid(outValid), .outReady(outReady), .realOutputBus(realOutputBus),
  .imagOutputBus(imagOutputBus), .growthIndicator(growthIndicator));

// ===== test/sample_partner.sv
// Sample source and result sink on the far side of the streams
module sample_partner (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Sample source
  output logic sampleValid,
  input wire sampleReady,
  output logic [18:0] realInputBus,
  output logic [18:0] imagInputBus,
  // Result sink, stall mode 0 ready, 1 random, 2 never
  input wire outValid,
  output logic outReady,
  input wire [19:0] realOutputBus,
  input wire [19:0] imagOutputBus,
  input wire [1:0] growthIndicator,
  input wire [1:0] stallMode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [37:0] txQ[$];
  logic [41:0] rxQ[$];
  initial begin
    sampleValid = 1'b0;
    outReady = 1'b0;
    realInputBus = 19'h0;
    imagInputBus = 19'h0;
  end
  // Sample held until taken; idle data toggles so nothing stale looks valid
  always @(posedge clk_sys) begin
    if (sampleValid && sampleReady) void'(txQ.pop_front());
    if (arst_n && txQ.size() != 0) begin
      sampleValid <= 1'b1;
      {realInputBus, imagInputBus} <= txQ[0];
    end else begin
      sampleValid <= 1'b0;
      realInputBus <= ~realInputBus;
      imagInputBus <= ~imagInputBus;
    end
    if (outValid && outReady) rxQ.push_back({growthIndicator, realOutputBus, imagOutputBus});
    outReady <= arst_n && (stallMode == 2'h0 || (stallMode == 2'h1 && $urandom_range(1) == 1));
  end
endmodule // sample_partner

// ===== test/tb_top.sv
// Self-checking bench for the multiplier formatting block
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, arst_n, hsel, hwrite;
  logic [1:0] htrans, stallMode, sh;
  logic [31:0] haddr, hwdata, rd, tmp;
  logic [15:0] cosV, sinV;
  logic [6:0] ctlV;
  logic [41:0] item;
  logic [34:0] pr[$], pi[$];
  logic [34:0] prR, prI, curR, curI;
  logic [19:0] accR, accI, eR, eI;
  wire hreadyout, hresp, sampleValid, sampleReady, outValid, outReady;
  wire [31:0] hrdata;
  wire [18:0] realInputBus, imagInputBus;
  wire [19:0] realOutputBus, imagOutputBus;
  wire [1:0] growthIndicator;
  int n_mismatch, n_checks, cyc, k;
  complex_multiplier_io_format_accumulate complex_multiplier_io_format_accumulate_inst (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .realInputBus(realInputBus), .imagInputBus(imagInputBus), .outValid(outValid),
    .outReady(outReady), .realOutputBus(realOutputBus), .imagOutputBus(imagOutputBus),
    .growthIndicator(growthIndicator));
  sample_partner partner_inst (.clk_sys(clk_sys), .arst_n(arst_n), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .realInputBus(realInputBus), .imagInputBus(imagInputBus), .outValid(outValid),
    .outReady(outReady), .realOutputBus(realOutputBus), .imagOutputBus(imagOutputBus),
    .growthIndicator(growthIndicator), .stallMode(stallMode));
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One AHB single transfer; request held until ready is seen
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Complex product of the selected sixteen input bits and the carrier
  function automatic logic [34:0] prod(logic [18:0] r, logic [18:0] i, logic im);
    logic signed [15:0] xr, xi;
    logic signed [34:0] p;
    xr = r[sh +: 16];
    xi = i[sh +: 16];
    p = im ? xr * $signed(sinV) + xi * $signed(cosV) : xr * $signed(cosV) - xi * $signed(sinV);
    return p;
  endfunction
  function automatic logic [19:0] fmt(logic [34:0] p, logic [34:0] prv, logic [1:0] src, logic bin);
    logic [19:0] v;
    case (src)
      2'h0: v = p[34:15];
      2'h1: v = {p[34:31], 1'b0, p[14:0]};
      2'h2: v = prv[34:15];
      default: v = 20'h0;
    endcase
    return {v[19] ^ ~bin, v[18:0]};
  endfunction
  task automatic send(input int n);
    logic [18:0] r, i;
    repeat (n) begin
      tmp = $urandom;
      r = tmp[18:0];
      tmp = $urandom;
      i = tmp[18:0];
      partner_inst.txQ.push_back({r, i});
      pr.push_back(prod(r, i, 1'b0));
      pi.push_back(prod(r, i, 1'b1));
    end
  endtask
  task automatic nextOut();
    while (partner_inst.rxQ.size() == 0) @(posedge clk_sys);
    item = partner_inst.rxQ.pop_front();
    prR = curR;
    prI = curI;
    curR = pr.pop_front();
    curI = pi.pop_front();
  endtask
  // Largest growth over the four watched windows of the newest sample's holding registers
  function automatic logic [1:0] gexp();
    logic [4:0] w[4];
    logic [1:0] g, m;
    w = '{curR[33:29], curI[33:29], prR[33:29], prI[33:29]};
    m = 2'h0;
    for (int q = 0; q < 4; q++) begin
      g = (w[q][4] != w[q][3]) ? 2'h3 : (w[q][3] != w[q][2]) ? 2'h2 : (w[q][2] != w[q][1]) ? 2'h1 : 2'h0;
      if (g > m) m = g;
    end
    return m;
  endfunction
  task automatic drain(input int n);
    for (int j = 0; j < n; j++) begin
      nextOut();
      `CHK("real out", fmt(curR, prR, ctlV[3:2], ctlV[5]), item[39:20])
      `CHK("imag out", fmt(curI, prI, ctlV[3:2], ctlV[5]), item[19:0])
      // Growth follows the holding registers, so only the last result of a batch is certain
      if (ctlV[6] && j == n - 1) `CHK("growth", gexp(), item[41:40])
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    {arst_n, hsel, hwrite, htrans, haddr, hwdata, stallMode} = '0;
    void'($urandom(32'h8258));
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // Reset values, unmapped place, extreme carrier
    bus(1'b0, 32'h0, 32'h0);
    `CHK("control reset", 32'h20, rd)
    bus(1'b0, 32'h4, 32'h0);
    `CHK("carrier reset", 32'h7fff, rd)
    bus(1'b1, 32'h14, 32'hffffffff);
    bus(1'b0, 32'h14, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    cosV = 16'h8000;
    sinV = 16'h7fff;
    bus(1'b1, 32'h4, {sinV, cosV});
    $display("test registers done");
    // Every shift, source and format code in unload mode under random stalls
    stallMode <= 2'h1;
    for (k = 0; k < 32; k++) begin
      ctlV = {k[4] ^ k[0], k[4], 1'b0, k[3:0]};
      sh = ctlV[1:0];
      bus(1'b1, 32'h0, {25'h0, ctlV});
      send(2);
      drain(2);
    end
    $display("test formatting done");
    // Summing freezes holding registers, unload dumps the total
    eR = prR[34:15];
    eI = prI[34:15];
    accR = curR[34:15];
    accI = curI[34:15];
    ctlV = 7'h38;
    sh = 2'h0;
    bus(1'b1, 32'h0, 32'h38);
    send(5);
    repeat (5) begin
      nextOut();
      accR += curR[34:15];
      accI += curI[34:15];
      `CHK("frozen real", eR, item[39:20])
      `CHK("frozen imag", eI, item[19:0])
    end
    ctlV = 7'h28;
    bus(1'b1, 32'h0, 32'h28);
    send(1);
    nextOut();
    `CHK("dump real", accR, item[39:20])
    `CHK("dump imag", accI, item[19:0])
    $display("test accumulate done");
    // Fill the buffer against a stalled sink, then drain it
    stallMode <= 2'h2;
    send(40);
    repeat (80) @(posedge clk_sys);
    `CHK("buffer full", 1'b0, sampleReady)
    stallMode <= 2'h0;
    drain(40);
    $display("test buffer done");
    final_report();
  end
endmodule // tb_top
